//--- bench/comparator_event_control_tb.sv
// Self-checking bench for the comparator event control block
`timescale 1ns/10ps

`define CHK(name, exp, got) begin checked++; if ((got) !== (exp)) begin failures++; \
	$display("mismatch %s expected %h seen %h", name, exp, got); end end

module comparator_event_control_tb;
	import comparator_pkg::*;

	logic              clk_in;
	logic              resetn_in;
	reg_req_s          req;
	logic [7:0]        rdata;
	logic [9:0]        pos;
	logic [9:0]        neg;
	logic              glob;
	logic              vec;
	logic              irq;
	logic              power_off;
	logic              result;
	logic              want_high;
	logic              auto_ack;
	int                checked;
	int                failures;

	comparator_event_control dut_u (
		.clk_in                   (clk_in),
		.resetn_in                (resetn_in),
		.positive_analog_input_in (pos),
		.negative_analog_input_in (neg),
		.reg_req_in               (req),
		.reg_rdata_out            (rdata),
		.global_irq_enable_in     (glob),
		.vector_taken_in          (vec),
		.irq_request_out          (irq),
		.comparator_power_off_out (power_off),
		.comparator_result_out    (result)
	);

	comparator_partner #(.BITS(10)) partner_u (
		.clk_in           (clk_in),
		.resetn_in        (resetn_in),
		.want_high_in     (want_high),
		.auto_ack_in      (auto_ack),
		.positive_out     (pos),
		.negative_out     (neg),
		.irq_request_in   (irq),
		.vector_taken_out (vec)
	);

	// ----------------------------------------------------------------
	// Clock, tasks and closing
	// ----------------------------------------------------------------
	// 200 MHz system clock
	always #2.5 clk_in = ~clk_in;

	task tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask : tick

	// Ordinary byte write, one-cycle strobe
	task wr(input logic [7:0] d);
		@(posedge clk_in);
		req <= '{write: 1'b1, bit_op: 1'b0, bit_index: 3'h0, bit_value: 1'b0, wdata: d};
		@(posedge clk_in);
		req <= '0;
	endtask : wr

	// Single-bit set or clear instruction
	task bop(input logic [2:0] idx, input logic val);
		@(posedge clk_in);
		req <= '{write: 1'b1, bit_op: 1'b1, bit_index: idx, bit_value: val, wdata: 8'h00};
		@(posedge clk_in);
		req <= '0;
	endtask : bop

	// Read data lags state by one cycle, so let two edges pass
	task rd(input logic [7:0] exp);
		tick(2);
		#1;
		`CHK("register", exp, rdata)
	endtask : rd

	task results;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		#20000;
		failures++;
		results();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		logic exp_flag;
		clk_in    = 1'b0;
		resetn_in = 1'b0;
		req       = '0;
		glob      = 1'b0;
		want_high = 1'b0;
		auto_ack  = 1'b0;
		checked   = 0;
		failures  = 0;
		tick(8);
		resetn_in <= 1'b1;
		rd(8'h00);
		`CHK("power off", 1'b0, power_off)
		// Power off with reserved bits written; result must stay low while unpowered
		wr(8'hC7);
		want_high <= 1'b1;
		tick(10);
		rd(8'h83);
		`CHK("power off", 1'b1, power_off)
		// Powering up yields a rising result; the flag sets with the enable clear
		wr(8'h03);
		tick(10);
		rd(8'h33);
		`CHK("result", 1'b1, result)
		wr(8'h13);
		rd(8'h23);
		// Every select code against a falling then a rising result
		for (int s = 0; s < 4; s++) begin
			for (int d = 0; d < 2; d++) begin
				wr({6'h04, s[1:0]});
				want_high <= d[0];
				tick(10);
				exp_flag = (s == 0) || (s == 2 && d == 0) || (s == 3 && d == 1);
				rd({2'b00, d[0], exp_flag, 2'b00, s[1:0]});
				`CHK("irq masked", 1'b0, irq)
			end
		end
		// Writing zero keeps the flag; a bit instruction elsewhere clears it
		wr(8'h03);
		rd(8'h33);
		bop(3'h1, 1'b0);
		rd(8'h21);
		// Interrupt needs flag, local and global enable; vector entry clears flag
		wr(8'h10);
		want_high <= 1'b0;
		tick(10);
		wr(8'h08);
		tick(3);
		#1;
		`CHK("irq no global", 1'b0, irq)
		// Inputs change only at a rising edge, never just after a check
		@(posedge clk_in);
		glob <= 1'b1;
		tick(2);
		#1;
		`CHK("irq raised", 1'b1, irq)
		@(posedge clk_in);
		auto_ack <= 1'b1;
		tick(6);
		#1;
		`CHK("irq dropped", 1'b0, irq)
		rd(8'h08);
		results();
	end
endmodule : comparator_event_control_tb

//--- bench/comparator_partner.sv
// Model of the comparator pins and of the core accepting the interrupt
`timescale 1ns/10ps

module comparator_partner #(
	parameter int unsigned BITS = 10
) (
	// Clock and reset
	input  wire logic            clk_in,
	input  wire logic            resetn_in,
	// Scenario controls
	input  wire logic            want_high_in,
	input  wire logic            auto_ack_in,
	// Pins and interrupt handshake
	output logic [BITS-1:0]      positive_out,
	output logic [BITS-1:0]      negative_out,
	input  wire logic            irq_request_in,
	output logic                 vector_taken_out
);
	logic [1:0] holdoff;

	// ----------------------------------------------------------------
	// Pins
	// ----------------------------------------------------------------
	// Negative pin sits mid-scale; positive sits one code above or below
	assign negative_out = {1'b1, {(BITS-1){1'b0}}};
	assign positive_out = want_high_in ? negative_out + 1'b1 : negative_out - 1'b1;

	// ----------------------------------------------------------------
	// Core
	// ----------------------------------------------------------------
	// One vector pulse per request; holdoff stops a second entry while the flag drains
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			vector_taken_out <= 1'b0;
			holdoff          <= 2'h0;
		end else begin
			vector_taken_out <= 1'b0;
			if (holdoff != 2'h0) begin
				holdoff <= holdoff - 2'h1;
			end else if (auto_ack_in && irq_request_in) begin
				vector_taken_out <= 1'b1;
				holdoff          <= 2'h3;
			end
		end
	end
endmodule : comparator_partner

//--- design/comparator_event_control.sv
// Control, status and event logic around the on-chip analog comparator
`timescale 1ns/10ps

// What this block does
// R1: Result is high when positive input exceeds negative input, else low.
// R2: Bit 5 reads the comparator result live, never latched.
// R3: Bit 7 powers the comparator off; settable at any time.
// R4: Software clears the interrupt enable before changing the power-off bit.
// R5: Event flag in bit 4 sets on a transition matching the selected edge.
// R6: Interrupt requested only with flag, local enable and global enable set.
// R7: Entering the comparator interrupt vector clears the event flag.
// R8: Writing one to the flag clears it; writing zero leaves it.
// R9: Single-bit instruction on another bit writes flag back, clearing it.
// R10: Bit 3 enables the interrupt; flag still sets when it is zero.
// R11: Select 00 toggle, 01 reserved, 10 falling, 11 rising.
// R12: Reserved bits 6 and 2 always read as zero.
// R13: Software clears the interrupt enable before changing event select.
// R14: Positive input is port B pin zero, negative is port B pin one.
// R15: Software makes both pins inputs with pull-ups off.
// R16: Result passes a synchroniser; edges compare against the previous sample.
// R17: Reset clears power-off, flag, enable and event select.
module comparator_event_control #(
	parameter int unsigned ANALOG_BITS = comparator_pkg::ANALOG_WIDTH
) (
	// Clock and reset
	input  wire logic                       clk_in,
	input  wire logic                       resetn_in,
	// Sampled levels on port B pin zero (positive) and pin one (negative)
	input  wire logic [ANALOG_BITS-1:0]     positive_analog_input_in,
	input  wire logic [ANALOG_BITS-1:0]     negative_analog_input_in,
	// Register access from the core
	input  wire comparator_pkg::reg_req_s   reg_req_in,
	output logic [7:0]                      reg_rdata_out,
	// Interrupt handshake with the core
	input  wire logic                       global_irq_enable_in,
	input  wire logic                       vector_taken_in,
	output logic                            irq_request_out,
	// Analog front end control and filtered result
	output logic                            comparator_power_off_out,
	output logic                            comparator_result_out
);
	import comparator_pkg::*;

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (ANALOG_BITS < 1) begin : g_bad_width
		$error("ANALOG_BITS must be at least one");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic       comparator_power_off;
	logic       comparator_event_flag;
	logic       comparator_irq_enable;
	logic [1:0] event_select;
	logic       level;
	logic       prev_level;
	logic       raw_compare;
	logic       event_hit;
	logic       flag_clear;
	logic [7:0] read_image;
	logic [7:0] write_image;

	// ----------------------------------------------------------------
	// Comparator and synchroniser
	// ----------------------------------------------------------------

	// An unpowered comparator reads low rather than floating
	assign raw_compare = !comparator_power_off
		&& (positive_analog_input_in > negative_analog_input_in); // [R1] [R3] [R14]

	// Three sampling flops and an agreement output flop filter the asynchronous comparator output
	comparator_sync u_sync (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.async_in  (raw_compare),
		.level_out (level)
	); // [R16]

	// Previous filtered sample for edge detection
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prev_level <= 1'b0;
		end else begin
			prev_level <= level; // [R16]
		end
	end

	// ----------------------------------------------------------------
	// Edge decode
	// ----------------------------------------------------------------

	// Reserved select never fires, so a stray setting is harmless
	always_comb begin
		case (event_select)
			SEL_TOGGLE:   event_hit = level ^ prev_level;   // [R11]
			SEL_FALLING:  event_hit = !level && prev_level; // [R11]
			SEL_RISING:   event_hit = level && !prev_level; // [R11]
			SEL_RESERVED: event_hit = 1'b0;                 // [R11]
			default:      event_hit = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Register image and write decode
	// ----------------------------------------------------------------

	// Live view of the register; reserved bits are tied low
	always_comb begin
		read_image                    = 8'h00; // [R12]
		read_image[BIT_POWER_OFF]     = comparator_power_off;
		read_image[BIT_RESULT]        = level; // [R2]
		read_image[BIT_EVENT_FLAG]    = comparator_event_flag;
		read_image[BIT_IRQ_ENABLE]    = comparator_irq_enable;
		read_image[BIT_SELECT_HIGH]   = event_select[1];
		read_image[BIT_SELECT_LOW]    = event_select[0];
	end

	// A single-bit instruction rewrites the whole byte it just read
	always_comb begin
		write_image = reg_req_in.wdata;
		if (reg_req_in.bit_op) begin
			write_image                       = read_image; // [R9]
			write_image[reg_req_in.bit_index] = reg_req_in.bit_value;
		end
	end

	// Vector entry or a one written to the flag position clears it
	assign flag_clear = vector_taken_in // [R7]
		|| (reg_req_in.write && write_image[BIT_EVENT_FLAG]); // [R8] [R9]

	// ----------------------------------------------------------------
	// Control bits
	// ----------------------------------------------------------------

	// Software may change these at any time; it guards its own interrupts
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			comparator_power_off  <= BIT_RESET;    // [R17]
			comparator_irq_enable <= BIT_RESET;    // [R17]
			event_select          <= SELECT_RESET; // [R17]
		end else if (reg_req_in.write) begin
			comparator_power_off  <= write_image[BIT_POWER_OFF]; // [R3]
			comparator_irq_enable <= write_image[BIT_IRQ_ENABLE]; // [R10]
			event_select          <= write_image[BIT_SELECT_HIGH:BIT_SELECT_LOW];
		end
	end

	// ----------------------------------------------------------------
	// Event flag
	// ----------------------------------------------------------------

	// A new event wins over a clear in the same cycle so none is lost
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			comparator_event_flag <= BIT_RESET; // [R17]
		end else if (event_hit) begin
			comparator_event_flag <= 1'b1; // [R5] [R10]
		end else if (flag_clear) begin
			comparator_event_flag <= 1'b0; // [R7] [R8] [R9]
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// Read data and request are registered, one cycle behind the state
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			reg_rdata_out   <= CSR_RESET_VALUE;
			irq_request_out <= 1'b0;
		end else begin
			reg_rdata_out   <= read_image; // [R2] [R12]
			irq_request_out <= comparator_event_flag && comparator_irq_enable
				&& global_irq_enable_in; // [R6] [R10]
		end
	end

	assign comparator_power_off_out = comparator_power_off; // Flop, drives the analog supply switch
	assign comparator_result_out    = level;                // Flop inside the synchroniser

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	property p_compare_high;
		@(posedge clk_in) disable iff (!resetn_in)
		(!comparator_power_off && positive_analog_input_in > negative_analog_input_in) [*5] |-> level;
	endproperty
	a_compare_high: assert property (p_compare_high) else $error("result not high for higher input"); // [R1]

	property p_power_off_low;
		@(posedge clk_in) disable iff (!resetn_in)
		comparator_power_off [*5] |-> !level;
	endproperty
	a_power_off_low: assert property (p_power_off_low) else $error("powered-off comparator reads high"); // [R3]

	property p_result_view;
		@(posedge clk_in) disable iff (!resetn_in)
		##1 reg_rdata_out[BIT_RESULT] == $past(level);
	endproperty
	a_result_view: assert property (p_result_view) else $error("result bit does not follow comparator"); // [R2]

	property p_reserved_zero;
		@(posedge clk_in) disable iff (!resetn_in)
		!reg_rdata_out[BIT_RESERVED_HIGH] && !reg_rdata_out[BIT_RESERVED_LOW];
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit reads nonzero"); // [R12]

	property p_rising_sets;
		@(posedge clk_in) disable iff (!resetn_in)
		(event_select == SEL_RISING && level && !prev_level) |=> comparator_event_flag ##1
			reg_rdata_out[BIT_EVENT_FLAG];
	endproperty
	a_rising_sets: assert property (p_rising_sets) else $error("rising edge did not set flag"); // [R5]

	property p_reserved_mode;
		@(posedge clk_in) disable iff (!resetn_in)
		(event_select == SEL_RESERVED && !comparator_event_flag && !reg_req_in.write) |=> !comparator_event_flag;
	endproperty
	a_reserved_mode: assert property (p_reserved_mode) else $error("reserved select raised flag"); // [R11]

	property p_irq_request;
		@(posedge clk_in) disable iff (!resetn_in)
		##1 irq_request_out == ($past(comparator_event_flag) && $past(comparator_irq_enable)
			&& $past(global_irq_enable_in));
	endproperty
	a_irq_request: assert property (p_irq_request) else $error("interrupt request mismatch"); // [R6]

	property p_vector_clear;
		@(posedge clk_in) disable iff (!resetn_in)
		(vector_taken_in && !event_hit) |=> !comparator_event_flag ##1 !irq_request_out;
	endproperty
	a_vector_clear: assert property (p_vector_clear) else $error("vector entry left flag set"); // [R7]

	property p_write_one_clears;
		@(posedge clk_in) disable iff (!resetn_in)
		(reg_req_in.write && !reg_req_in.bit_op && reg_req_in.wdata[BIT_EVENT_FLAG] && !event_hit)
			|=> !comparator_event_flag;
	endproperty
	a_write_one_clears: assert property (p_write_one_clears) else $error("write one did not clear flag"); // [R8]

	property p_write_zero_keeps;
		@(posedge clk_in) disable iff (!resetn_in)
		(reg_req_in.write && !reg_req_in.bit_op && !reg_req_in.wdata[BIT_EVENT_FLAG]
			&& !vector_taken_in && comparator_event_flag) |=> comparator_event_flag;
	endproperty
	a_write_zero_keeps: assert property (p_write_zero_keeps) else $error("write zero cleared flag"); // [R8]

	property p_bit_op_clears;
		@(posedge clk_in) disable iff (!resetn_in)
		(reg_req_in.write && reg_req_in.bit_op && reg_req_in.bit_index != INDEX_EVENT_FLAG
			&& comparator_event_flag && !event_hit) |=> !comparator_event_flag;
	endproperty
	a_bit_op_clears: assert property (p_bit_op_clears) else $error("bit instruction kept pending flag"); // [R9]

	property p_disabled_flag_sets;
		@(posedge clk_in) disable iff (!resetn_in)
		(event_hit && !comparator_irq_enable && !(reg_req_in.write && write_image[BIT_IRQ_ENABLE]))
			|=> comparator_event_flag ##1 !irq_request_out;
	endproperty
	a_disabled_flag_sets: assert property (p_disabled_flag_sets) else $error("disabled flag or request wrong"); // [R10]

endmodule : comparator_event_control

//--- design/comparator_pkg.sv
// Shared constants and types for the comparator event control block
package comparator_pkg;

	// ----------------------------------------------------------------
	// Control/status register layout
	// ----------------------------------------------------------------
	localparam int unsigned  CSR_WIDTH         = 8;
	localparam int unsigned  BIT_POWER_OFF     = 7;
	localparam int unsigned  BIT_RESERVED_HIGH = 6;
	localparam int unsigned  BIT_RESULT        = 5;
	localparam int unsigned  BIT_EVENT_FLAG    = 4;
	localparam int unsigned  BIT_IRQ_ENABLE    = 3;
	localparam int unsigned  BIT_RESERVED_LOW  = 2;
	localparam int unsigned  BIT_SELECT_HIGH   = 1;
	localparam int unsigned  BIT_SELECT_LOW    = 0;
	localparam logic [2:0]   INDEX_EVENT_FLAG  = 3'h4;
	localparam logic [7:0]   CSR_RESET_VALUE   = 8'h00;

	// ----------------------------------------------------------------
	// Event-select encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0]   SEL_TOGGLE        = 2'h0;
	localparam logic [1:0]   SEL_RESERVED      = 2'h1;
	localparam logic [1:0]   SEL_FALLING       = 2'h2;
	localparam logic [1:0]   SEL_RISING        = 2'h3;
	localparam logic [1:0]   SELECT_RESET      = 2'h0;
	localparam logic         BIT_RESET         = 1'b0;

	// Resolution of the sampled analog levels at the two comparator pins
	localparam int unsigned  ANALOG_WIDTH      = 10;

	// Cycles from a steady comparator level to the filtered result
	localparam int unsigned  SYNC_LATENCY      = 4;

	// ----------------------------------------------------------------
	// Register access request from the processor core
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       write;     // One-cycle write strobe
		logic       bit_op;    // Write comes from a single-bit set/clear instruction
		logic [2:0] bit_index; // Bit touched by a single-bit instruction
		logic       bit_value; // Value a single-bit instruction puts there
		logic [7:0] wdata;     // Full byte for an ordinary write
	} reg_req_s;

endpackage : comparator_pkg

//--- design/comparator_sync.sv
// Three-stage synchroniser with agreement filter for the comparator level
`timescale 1ns/10ps

module comparator_sync (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic resetn_in,
	// Asynchronous level and its filtered copy
	input  wire logic async_in,
	output logic      level_out
);

	// ----------------------------------------------------------------
	// Sampling chain
	// ----------------------------------------------------------------
	logic stage1;
	logic stage2;
	logic stage3;

	// Only stage2 reads stage1, keeping the metastable flop isolated
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// A change counts once the second and third stage agree
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			level_out <= 1'b0;
		end else if (stage2 == stage3) begin
			level_out <= stage3;
		end
	end

endmodule : comparator_sync
